//--- src/upcr_regs.sv
// Purpose: transceiver, interface mode and otg_line_ctl registers with line controls
// Assumes: register strobes and hardware events come from logic on clk; the
//          vbus comparator and external indicator are asynchronous pins
// Notes: reads answer one cycle after the read strobe

`timescale 1ns/1ps

module upcr_regs
    import upcr_pkg::*;
#(
    parameter logic [7:0] PRODUCT_IDENT_HIGH = 8'h5a, // arbitrary value
    parameter int RESET_CYCLES = XCVR_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic low_power_exit,
    input wire logic serial_mode_exit,
    input wire logic car_mode_exit,
    input wire logic host_mode,
    input wire logic vbus_comp_in,
    input wire logic ext_vbus_indicator_in,
    output logic [1:0] transceiver_speed_select,
    output logic termination_select,
    output logic [1:0] encoding_operation,
    output logic xcvr_reset,
    output logic low_power_request_n,
    output logic low_power_active,
    output logic hs_termination_en,
    output logic dplus_pullup_en,
    output logic dminus_pullup_en,
    output logic line_drive_en,
    output logic serial_six_pin_sel,
    output logic serial_three_pin_sel,
    output logic car_adapter_sel,
    output logic link_clock_run,
    output logic resume_auto_en,
    output logic vbus_valid,
    output logic stp_pullup_en,
    output logic id_pin_pullup,
    output logic dplus_pulldown,
    output logic dminus_pulldown,
    output logic vbus_discharge,
    output logic vbus_charge,
    output logic charge_pump_enable
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // which of the three addresses of a register was hit
    function automatic upcr_op_t decode_op(input logic [5:0] addr, input logic [5:0] base);
        upcr_op_t op;
        op = UPCR_OP_NONE;
        if (addr == base) begin
            op = UPCR_OP_WRITE;
        end else if (addr == 6'(base + 6'h01)) begin
            op = UPCR_OP_SET;
        end else if (addr == 6'(base + 6'h02)) begin
            op = UPCR_OP_CLEAR;
        end
        return op;
    endfunction : decode_op

    // apply a plain write, set or clear to a register value
    function automatic logic [7:0] apply_op(input logic [7:0] old, input logic [7:0] data,
                                            input upcr_op_t op);
        logic [7:0] val;
        val = old;
        case (op)
            UPCR_OP_WRITE: val = data;
            UPCR_OP_SET: val = old | data;
            UPCR_OP_CLEAR: val = old & ~data;
            default: val = old;
        endcase
        return val;
    endfunction : apply_op

    // does this access leave the given bit at one
    function automatic logic writes_one(input logic [7:0] data, input upcr_op_t op,
                                        input int pos);
        return (op == UPCR_OP_WRITE || op == UPCR_OP_SET) && data[pos];
    endfunction : writes_one

    // ****************************************************************
    // state
    // ****************************************************************

    typedef struct packed {
        logic [7:0] fn_ctl;
        logic [7:0] if_ctl;
        logic [7:0] otg_ctl;
        upcr_state_t state;
        logic [7:0] rst_cnt;
        logic [7:0] rdata;
        logic rvalid;
        logic [2:0] comp_sync;
        logic [2:0] ext_sync;
        logic comp_f;
        logic ext_f;
    } upcr_regs_t;

    upcr_regs_t s;
    upcr_regs_t next_s;
    upcr_op_t fn_op;
    upcr_op_t if_op;
    upcr_op_t otg_op;

    // decode is only live while a write strobe stands
    assign fn_op = reg_wr ? decode_op(reg_addr, ADDR_FN_WRITE) : UPCR_OP_NONE;
    assign if_op = reg_wr ? decode_op(reg_addr, ADDR_IF_WRITE) : UPCR_OP_NONE;
    assign otg_op = reg_wr ? decode_op(reg_addr, ADDR_OTG_WRITE) : UPCR_OP_NONE;

    // ****************************************************************
    // next state
    // ****************************************************************

    // software access first, then hardware events, then the sequencer
    always_comb begin
        next_s = s;
        // read path; unmapped addresses answer zero
        next_s.rvalid = reg_rd;
        if (reg_rd) begin
            if (reg_addr == ADDR_PRODUCT_IDENT_HIGH) begin
                next_s.rdata = PRODUCT_IDENT_HIGH;
            end else if (reg_addr >= ADDR_FN_WRITE && reg_addr <= ADDR_FN_CLEAR) begin
                next_s.rdata = s.fn_ctl;
            end else if (reg_addr >= ADDR_IF_WRITE && reg_addr <= ADDR_IF_CLEAR) begin
                next_s.rdata = s.if_ctl;
            end else if (reg_addr >= ADDR_OTG_WRITE && reg_addr <= ADDR_OTG_CLEAR) begin
                next_s.rdata = s.otg_ctl;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
        // writes; the top function bit is never stored
        next_s.fn_ctl = apply_op(s.fn_ctl, reg_wdata, fn_op) & FN_WRITABLE;
        next_s.if_ctl = apply_op(s.if_ctl, reg_wdata, if_op);
        next_s.otg_ctl = apply_op(s.otg_ctl, reg_wdata, otg_op);
        // mode ends clear their select bits unless software sets them in the same cycle
        if (serial_mode_exit && !writes_one(reg_wdata, if_op, IF_SERIAL_SIX)) begin
            next_s.if_ctl[IF_SERIAL_SIX] = 1'b0;
        end
        if (serial_mode_exit && !writes_one(reg_wdata, if_op, IF_SERIAL_THREE)) begin
            next_s.if_ctl[IF_SERIAL_THREE] = 1'b0;
        end
        if (car_mode_exit && !writes_one(reg_wdata, if_op, IF_CAR_ADAPTER)) begin
            next_s.if_ctl[IF_CAR_ADAPTER] = 1'b0;
        end
        // pin synchronisers: a change counts once stages two and three agree
        next_s.comp_sync = {s.comp_sync[1:0], vbus_comp_in};
        next_s.ext_sync = {s.ext_sync[1:0], ext_vbus_indicator_in};
        if (s.comp_sync[1] == s.comp_sync[2]) begin
            next_s.comp_f = s.comp_sync[2];
        end
        if (s.ext_sync[1] == s.ext_sync[2]) begin
            next_s.ext_f = s.ext_sync[2];
        end
        // sequencer for transceiver reset and low power
        case (s.state)
            UPCR_RUN: begin
                if (next_s.fn_ctl[FN_XCVR_RESET]) begin
                    next_s.state = UPCR_XCVR_RESET;
                    next_s.rst_cnt = 8'(RESET_CYCLES);
                end else if (!next_s.fn_ctl[FN_LOW_POWER_N]) begin
                    next_s.state = UPCR_LOW_POWER;
                end
            end
            UPCR_XCVR_RESET: begin
                // a fresh write of one restarts the reset; a write that clears the bit ends it early
                if (writes_one(reg_wdata, fn_op, FN_XCVR_RESET)) begin
                    next_s.rst_cnt = 8'(RESET_CYCLES);
                end else if (s.rst_cnt <= 8'h01) begin
                    next_s.fn_ctl[FN_XCVR_RESET] = 1'b0;
                    next_s.state = UPCR_RUN;
                end else begin
                    next_s.rst_cnt = s.rst_cnt - 8'h01;
                    if (!next_s.fn_ctl[FN_XCVR_RESET]) begin
                        next_s.state = UPCR_RUN;
                    end
                end
            end
            UPCR_LOW_POWER: begin
                // hardware set wins over a clear in the same cycle
                if (low_power_exit || next_s.fn_ctl[FN_LOW_POWER_N]) begin
                    next_s.fn_ctl[FN_LOW_POWER_N] = 1'b1;
                    next_s.state = UPCR_RUN;
                end
            end
            default: begin
                next_s.state = UPCR_RUN;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // every field takes a constant under reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s.fn_ctl <= FN_RESET;
            s.if_ctl <= IF_RESET;
            s.otg_ctl <= OTG_RESET;
            s.state <= UPCR_RUN;
            s.rst_cnt <= 8'h00;
            s.rdata <= 8'h00;
            s.rvalid <= 1'b0;
            s.comp_sync <= 3'h0;
            s.ext_sync <= 3'h0;
            s.comp_f <= 1'b0;
            s.ext_f <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    logic host_pulldowns;
    logic ind_level;
    logic alt_mode;

    // register fields to the analog controls; stp_pullup_en is inverted, low_power_active comes from the sequencer state
    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign transceiver_speed_select = s.fn_ctl[FN_SPEED_LSB +: 2];
    assign termination_select = s.fn_ctl[FN_TERM];
    assign encoding_operation = s.fn_ctl[FN_ENC_LSB +: 2];
    assign xcvr_reset = s.fn_ctl[FN_XCVR_RESET];
    assign low_power_request_n = s.fn_ctl[FN_LOW_POWER_N];
    assign low_power_active = (s.state == UPCR_LOW_POWER);
    assign serial_six_pin_sel = s.if_ctl[IF_SERIAL_SIX];
    assign serial_three_pin_sel = s.if_ctl[IF_SERIAL_THREE];
    assign car_adapter_sel = s.if_ctl[IF_CAR_ADAPTER];
    assign stp_pullup_en = !s.if_ctl[IF_STP_PULLUP_DIS];
    assign id_pin_pullup = s.otg_ctl[OTG_ID_PULLUP];
    assign dplus_pulldown = s.otg_ctl[OTG_DP_PULLDOWN];
    assign dminus_pulldown = s.otg_ctl[OTG_DM_PULLDOWN];
    assign vbus_discharge = s.otg_ctl[OTG_VBUS_DISCHARGE];
    assign vbus_charge = s.otg_ctl[OTG_VBUS_CHARGE];
    assign charge_pump_enable = s.otg_ctl[OTG_DRIVE_INTERNAL] | s.otg_ctl[OTG_DRIVE_ALT];

    // termination: both pull-downs mean a host port, which never pulls up
    assign host_pulldowns = dplus_pulldown && dminus_pulldown;
    assign hs_termination_en = (transceiver_speed_select == SPEED_HIGH) && !termination_select
                               && (encoding_operation != ENC_NON_DRIVING);
    assign dplus_pullup_en = termination_select && !host_pulldowns
                             && (transceiver_speed_select != SPEED_LOW);
    assign dminus_pullup_en = termination_select && !host_pulldowns
                              && (transceiver_speed_select == SPEED_LOW);
    // reserved encoding 11b is treated as non-driving for line drive only; hs termination still follows speed and termination select
    assign line_drive_en = (encoding_operation == ENC_NORMAL)
                           || (encoding_operation == ENC_RAW);

    // link clock stops in the alternate modes unless kept alive, and in low power
    assign alt_mode = serial_six_pin_sel || serial_three_pin_sel || car_adapter_sel;
    assign link_clock_run = !low_power_active
                            && (!alt_mode || s.if_ctl[IF_CLOCK_KEEP]);
    assign resume_auto_en = s.if_ctl[IF_RESUME_AUTO] && host_mode;

    // vbus valid source selection
    assign ind_level = s.ext_f ^ s.if_ctl[IF_IND_INVERT];
    assign vbus_valid = !s.otg_ctl[OTG_IND_EXTERNAL] ? s.comp_f :
                        (s.if_ctl[IF_IND_BYPASS] ? ind_level : (ind_level && s.comp_f));

    // ****************************************************************
    // assertions
    // ****************************************************************

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_product_read: assert property (reg_rd && reg_addr == ADDR_PRODUCT_IDENT_HIGH
        |=> reg_rvalid && reg_rdata == PRODUCT_IDENT_HIGH)
        else $error("product byte read wrong");
    a_iface_set: assert property (reg_wr && reg_addr == ADDR_IF_SET && !serial_mode_exit
        && !car_mode_exit |=> s.if_ctl == ($past(s.if_ctl) | $past(reg_wdata)))
        else $error("set write did not OR data");
    a_fn_clear: assert property (reg_wr && reg_addr == ADDR_FN_CLEAR
        && s.state == UPCR_RUN |=> (s.fn_ctl & $past(reg_wdata)) == 8'h00)
        else $error("clear write left bits set");
    a_fn_top_zero: assert property (reg_rd && reg_addr == ADDR_FN_WRITE
        |=> !reg_rdata[7])
        else $error("reserved function bit read one");
    // the reset length is a parameter, so it is checked through the counter
    a_reset_load: assert property ($rose(xcvr_reset) && s.state == UPCR_XCVR_RESET
        |-> s.rst_cnt == 8'(RESET_CYCLES))
        else $error("transceiver reset length not loaded");
    a_reset_count: assert property (s.state == UPCR_XCVR_RESET && s.rst_cnt > 8'h01
        && fn_op == UPCR_OP_NONE |=> xcvr_reset && s.rst_cnt == $past(s.rst_cnt) - 8'h01)
        else $error("transceiver reset count wrong");
    a_reset_len: assert property (s.state == UPCR_XCVR_RESET && s.rst_cnt <= 8'h01
        && fn_op == UPCR_OP_NONE |=> !xcvr_reset && s.state == UPCR_RUN)
        else $error("transceiver reset did not clear itself");
    a_low_power_exit: assert property (low_power_active && low_power_exit
        |=> low_power_request_n && !low_power_active)
        else $error("low power exit did not set bit");
    a_serial_clear: assert property (serial_mode_exit && !reg_wr
        |=> !serial_six_pin_sel && !serial_three_pin_sel)
        else $error("serial select not cleared");
    a_clock_gate: assert property (alt_mode && !s.if_ctl[IF_CLOCK_KEEP]
        |-> !link_clock_run)
        else $error("link clock ran in alternate mode");
    a_pump_write: assert property (reg_wr && reg_addr == ADDR_OTG_WRITE
        |=> charge_pump_enable == ($past(reg_wdata[5]) | $past(reg_wdata[6])))
        else $error("charge pump enable wrong");
    a_vbus_bypass: assert property (s.otg_ctl[OTG_IND_EXTERNAL]
        && s.if_ctl[IF_IND_BYPASS] |-> vbus_valid == (s.ext_f ^ s.if_ctl[IF_IND_INVERT]))
        else $error("vbus valid source wrong");
    a_resume_host: assert property (resume_auto_en |-> host_mode)
        else $error("auto resume outside host mode");

endmodule : upcr_regs

//--- shared/upcr_pkg.sv
// Purpose: constants shared by the transceiver control register bank
// Assumes: 8-bit registers, 6-bit immediate register addresses, 125 MHz clock
// Notes: offsets, field positions, reset values and timing counts live only here

package upcr_pkg;

    // ****************************************************************
    // register addresses: read at base..base+2, write base, set +1, clear +2
    // ****************************************************************
    localparam logic [5:0] ADDR_PRODUCT_IDENT_HIGH = 6'h03;
    localparam logic [5:0] ADDR_FN_WRITE = 6'h04;
    localparam logic [5:0] ADDR_FN_SET = 6'h05;
    localparam logic [5:0] ADDR_FN_CLEAR = 6'h06;
    localparam logic [5:0] ADDR_IF_WRITE = 6'h07;
    localparam logic [5:0] ADDR_IF_SET = 6'h08;
    localparam logic [5:0] ADDR_IF_CLEAR = 6'h09;
    localparam logic [5:0] ADDR_OTG_WRITE = 6'h0a;
    localparam logic [5:0] ADDR_OTG_SET = 6'h0b;
    localparam logic [5:0] ADDR_OTG_CLEAR = 6'h0c;

    // ****************************************************************
    // reset values and writable masks
    // ****************************************************************
    localparam logic [7:0] FN_RESET = 8'h41;
    localparam logic [7:0] FN_WRITABLE = 8'h7f;
    localparam logic [7:0] IF_RESET = 8'h00;
    localparam logic [7:0] OTG_RESET = 8'h06;

    // ****************************************************************
    // field positions, transceiver function register
    // ****************************************************************
    localparam int FN_SPEED_LSB = 0;
    localparam int FN_TERM = 2;
    localparam int FN_ENC_LSB = 3;
    localparam int FN_XCVR_RESET = 5;
    localparam int FN_LOW_POWER_N = 6;

    // interface mode register
    localparam int IF_SERIAL_SIX = 0;
    localparam int IF_SERIAL_THREE = 1;
    localparam int IF_CAR_ADAPTER = 2;
    localparam int IF_CLOCK_KEEP = 3;
    localparam int IF_RESUME_AUTO = 4;
    localparam int IF_IND_INVERT = 5;
    localparam int IF_IND_BYPASS = 6;
    localparam int IF_STP_PULLUP_DIS = 7;

    // otg line register
    localparam int OTG_ID_PULLUP = 0;
    localparam int OTG_DP_PULLDOWN = 1;
    localparam int OTG_DM_PULLDOWN = 2;
    localparam int OTG_VBUS_DISCHARGE = 3;
    localparam int OTG_VBUS_CHARGE = 4;
    localparam int OTG_DRIVE_INTERNAL = 5;
    localparam int OTG_DRIVE_ALT = 6;
    localparam int OTG_IND_EXTERNAL = 7;

    // ****************************************************************
    // speed and encoding codes
    // ****************************************************************
    localparam logic [1:0] SPEED_HIGH = 2'h0;
    localparam logic [1:0] SPEED_FULL = 2'h1;
    localparam logic [1:0] SPEED_LOW = 2'h2;
    localparam logic [1:0] SPEED_FULL_PREAMBLE = 2'h3;
    localparam logic [1:0] ENC_NORMAL = 2'h0;
    localparam logic [1:0] ENC_NON_DRIVING = 2'h1;
    localparam logic [1:0] ENC_RAW = 2'h2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int XCVR_RESET_NS = 80;
    localparam int XCVR_RESET_CYCLES = (XCVR_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // write operation decoded from the address
    typedef enum logic [1:0] {
        UPCR_OP_NONE = 2'h0,
        UPCR_OP_WRITE = 2'h1,
        UPCR_OP_SET = 2'h2,
        UPCR_OP_CLEAR = 2'h3
    } upcr_op_t;

    // sequencer states, gray along run -> reset and run -> low power
    typedef enum logic [1:0] {
        UPCR_RUN = 2'h0,
        UPCR_XCVR_RESET = 2'h1,
        UPCR_LOW_POWER = 2'h2
    } upcr_state_t;

endpackage : upcr_pkg

//--- verif/upcr_link_model.sv
// Purpose: link-side model issuing single register reads and writes
// Assumes: one strobe cycle per access, read answer one cycle after the strobe
// Notes: address and data are scrambled once released so stale values never match

`timescale 1ns/1ps

module upcr_link_model
    import upcr_pkg::*;
(
    input wire logic clk,
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    // idle bus at time zero
    initial begin
        reg_addr = 6'h3f;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one write, strobe for a single cycle
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // one read; rvalid stands for one cycle only, so the answer is taken at the
    // edge that ends that cycle, before the design updates it
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : upcr_link_model

//--- verif/upcr_regs_test.sv
// Purpose: self-checking bench for the transceiver control register bank
// Assumes: short transceiver reset length so the run stays brief
// Notes: pin levels are checked one step after the edge that updates them

`timescale 1ns/1ps

module upcr_regs_test;
    import upcr_pkg::*;
    // ****************************************************************
    // bench signals and instances
    // ****************************************************************
    localparam int RST_LEN = 2;
    localparam logic [7:0] ID_HIGH = 8'ha7; // arbitrary value
    logic clk = 1'b0, nrst = 1'b0, host_mode = 1'b0, vbus_comp_in = 1'b1;
    logic ext_vbus_indicator_in = 1'b1, reg_wr, reg_rd, reg_rvalid, xcvr_reset;
    logic [2:0] ev = 3'h0;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [1:0] transceiver_speed_select;
    logic low_power_request_n, low_power_active, link_clock_run, serial_six_pin_sel;
    logic serial_three_pin_sel, car_adapter_sel, resume_auto_en, vbus_valid, v;
    logic stp_pullup_en, dplus_pulldown, charge_pump_enable;
    logic termination_select, hs_termination_en, dplus_pullup_en, dminus_pullup_en;
    logic line_drive_en, id_pin_pullup, dminus_pulldown, vbus_discharge, vbus_charge;
    logic [1:0] encoding_operation;
    logic [2:0] mode_sel;
    logic [3:0] term_bits;
    int n_errors = 0, n_checks = 0;

    always #4 clk = ~clk;

    upcr_regs #(.PRODUCT_IDENT_HIGH(ID_HIGH), .RESET_CYCLES(RST_LEN)) dut_u (
        .clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .low_power_exit(ev[0]), .serial_mode_exit(ev[1]), .car_mode_exit(ev[2]),
        .host_mode, .vbus_comp_in, .ext_vbus_indicator_in, .transceiver_speed_select,
        .termination_select, .encoding_operation, .xcvr_reset, .low_power_request_n,
        .low_power_active, .hs_termination_en, .dplus_pullup_en, .dminus_pullup_en,
        .line_drive_en, .serial_six_pin_sel, .serial_three_pin_sel, .car_adapter_sel,
        .link_clock_run, .resume_auto_en, .vbus_valid, .stp_pullup_en, .id_pin_pullup,
        .dplus_pulldown, .dminus_pulldown, .vbus_discharge, .vbus_charge,
        .charge_pump_enable);
    upcr_link_model link_u (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);

    // grouped pins for compact compares
    assign mode_sel = {serial_six_pin_sel, serial_three_pin_sel, car_adapter_sel};
    assign term_bits = {hs_termination_en, dplus_pullup_en, dminus_pullup_en, line_drive_en};

    // ****************************************************************
    // helpers and scenarios
    // ****************************************************************
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // read one address and expect an answer
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] exp);
        link_u.rd(a, d, v);
        chk(v, 1'b1);
        chk(d, exp);
    endtask : chk_rd

    // one cycle event pulse, settled after the edge that takes it
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
        #1;
    endtask : pulse

    // reset values of registers and pins
    task automatic t_reset();
        chk_rd(ADDR_PRODUCT_IDENT_HIGH, ID_HIGH);
        for (int a = 4; a < 7; a++) chk_rd(6'(a), 8'h41);
        chk_rd(ADDR_IF_WRITE, 8'h00);
        chk_rd(ADDR_OTG_CLEAR, 8'h06);
        chk_rd(6'h3f, 8'h00);
        chk({dplus_pulldown, stp_pullup_en, charge_pump_enable}, 8'h06);
    endtask : t_reset

    // read-only byte, top bit, self-clearing transceiver reset, clear and speed select
    task automatic t_fn();
        link_u.wr(ADDR_PRODUCT_IDENT_HIGH, 8'hff);
        chk_rd(ADDR_PRODUCT_IDENT_HIGH, ID_HIGH);
        link_u.wr(ADDR_FN_WRITE, 8'hff);
        #1 chk(xcvr_reset, 1'b1);
        repeat (RST_LEN + 2) @(posedge clk);
        #1 chk(xcvr_reset, 1'b0);
        chk_rd(ADDR_FN_SET, 8'h5f);
        link_u.wr(ADDR_FN_CLEAR, 8'h1f);
        chk_rd(ADDR_FN_WRITE, 8'h40);
        for (int s = 0; s < 4; s++) begin
            link_u.wr(ADDR_FN_WRITE, 8'h40 | 8'(s));
            #1 chk(transceiver_speed_select, 8'(s));
        end
    endtask : t_fn

    // low power entry by clearing the request and exit by event
    task automatic t_low_power();
        link_u.wr(ADDR_FN_CLEAR, 8'h40);
        #1 chk(low_power_request_n, 1'b0);
        @(posedge clk);
        #1 chk({low_power_active, link_clock_run}, 8'h02);
        pulse(3'h1);
        chk({low_power_request_n, low_power_active}, 8'h02);
    endtask : t_low_power

    // alternate modes, their exits, clock keep-alive and auto resume
    task automatic t_modes();
        link_u.wr(ADDR_IF_SET, 8'h0f);
        #1 chk(mode_sel, 8'h07);
        chk(link_clock_run, 1'b1);
        link_u.wr(ADDR_IF_CLEAR, 8'h08);
        #1 chk(link_clock_run, 1'b0);
        pulse(3'h2);
        chk(mode_sel, 8'h01);
        pulse(3'h4);
        chk({car_adapter_sel, link_clock_run}, 8'h01);
        link_u.wr(ADDR_IF_SET, 8'h10);
        #1 chk(resume_auto_en, 1'b0);
        @(posedge clk);
        host_mode <= 1'b1;
        #1 chk(resume_auto_en, 1'b1);
    endtask : t_modes

    // charge pump, pull-downs, vbus valid source selection
    task automatic t_otg();
        link_u.wr(ADDR_OTG_WRITE, 8'h20);
        #1 chk({charge_pump_enable, dplus_pulldown}, 8'h02);
        link_u.wr(ADDR_OTG_CLEAR, 8'h20);
        #1 chk(charge_pump_enable, 1'b0);
        link_u.wr(ADDR_OTG_SET, 8'h40);
        #1 chk(charge_pump_enable, 1'b1);
        link_u.wr(ADDR_OTG_WRITE, 8'h80);
        #1 chk(vbus_valid, 1'b1);
        link_u.wr(ADDR_IF_SET, 8'h20);
        #1 chk(vbus_valid, 1'b0);
        link_u.wr(ADDR_IF_CLEAR, 8'h20);
        link_u.wr(ADDR_IF_SET, 8'hc0);
        vbus_comp_in <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk({vbus_valid, stp_pullup_en}, 8'h02);
        link_u.wr(ADDR_OTG_WRITE, 8'h00);
        #1 chk(vbus_valid, 1'b0);
    endtask : t_otg

    // termination, encoding and otg line controls
    task automatic t_lines();
        link_u.wr(ADDR_FN_WRITE, 8'h44);
        #1 chk(term_bits, 8'h05);
        link_u.wr(ADDR_FN_WRITE, 8'h46);
        #1 chk(term_bits, 8'h03);
        link_u.wr(ADDR_FN_WRITE, 8'h50);
        #1 chk({termination_select, encoding_operation, term_bits}, 8'h29);
        link_u.wr(ADDR_FN_WRITE, 8'h48);
        #1 chk(term_bits, 8'h00);
        link_u.wr(ADDR_OTG_WRITE, 8'h1f);
        #1 chk({id_pin_pullup, dminus_pulldown}, 8'h03);
        chk({vbus_discharge, vbus_charge}, 8'h03);
        link_u.wr(ADDR_FN_WRITE, 8'h44);
        #1 chk(term_bits, 8'h01);
    endtask : t_lines

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_fn();
        t_low_power();
        t_modes();
        t_otg();
        t_lines();
        stop_test();
    end

    // a hang counts as a failure; the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule : upcr_regs_test
